/* File: core/cgms_pkg.sv */
// Constants, modes and states of the clock generation mode select block.
package cgms_pkg;

	typedef enum logic [1:0] {
		CGMS_DIRECT,
		CGMS_PRESCALER,
		CGMS_PLL,
		CGMS_PLL_BASE
	} cgms_mode_t;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_RUN,
		ST_DRAIN,
		ST_LOCK,
		ST_ARM
	} cgms_state_t;

	localparam int unsigned CLOCK_PERIOD_PS   = 5000;
	localparam int unsigned INIT_TIME_NS      = 100;
	localparam int unsigned INIT_CYCLES       = (INIT_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1)
		/ CLOCK_PERIOD_PS;
	localparam int unsigned LOCK_TIME_NS      = 2000;
	localparam int unsigned LOCK_CYCLES       = (LOCK_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1)
		/ CLOCK_PERIOD_PS;
	localparam int unsigned TIMER_W           = 12;
	localparam int unsigned PERIOD_W          = 16;
	localparam logic [PERIOD_W-1:0] VCO_BASE_STEP  = 16'h0003;
	localparam logic [PERIOD_W-1:0] VCO_BASE_LIMIT = 16'h0010;
	localparam cgms_mode_t RESET_MODE         = CGMS_DIRECT;

endpackage

/* File: core/cgms_divider.sv */
// Edge-counting clock divider that changes its output only on source rising edges for divisors above one.
`timescale 1ns/1ps
`default_nettype none
module cgms_divider #(
	parameter int unsigned DIV_W = 4
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Source clock level and its rising edge
	input  wire logic             src,
	input  wire logic             src_rise,
	input  wire logic [DIV_W-1:0] divisor,
	// Divided clock
	output logic                  out,
	output logic                  out_rise
);

	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic             out_reg;
	logic             out_next;
	logic             rise_reg;
	logic             rise_next;
	logic [DIV_W-1:0] half;
	logic [DIV_W:0]   inc;

	// A divisor of zero or one passes the source through.
	always_comb
	begin
		half      = DIV_W'((DIV_W + 1)'(divisor) + (DIV_W + 1)'(1) >> 1);
		inc       = (DIV_W + 1)'(cnt_reg) + (DIV_W + 1)'(1);
		cnt_next  = cnt_reg;
		out_next  = out_reg;
		if (divisor <= DIV_W'(1))
		begin
			cnt_next = '0;
			out_next = src;
		end
		else if (src_rise)
		begin
			cnt_next = (inc >= (DIV_W + 1)'(divisor)) ? '0 : inc[DIV_W-1:0];
			out_next = (cnt_next < half);
		end
		rise_next = out_next & ~out_reg;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cnt_reg  <= '0;
			out_reg  <= 1'b0;
			rise_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			out_reg  <= out_next;
			rise_reg <= rise_next;
		end
	end

	assign out      = out_reg;
	assign out_rise = rise_reg;

endmodule
`default_nettype wire

/* File: core/cgms_core.sv */
// Clock generation unit: mode selection, dividers, VCO model, safe switching, gating.
`timescale 1ns/1ps
`default_nettype none
module cgms_core #(
	parameter int unsigned P_W         = 4,
	parameter int unsigned N_W         = 6,
	parameter int unsigned K_W         = 4,
	parameter int unsigned NUM_MODULES = 8
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// Oscillator input
	input  wire logic                   oscillator_clock,
	// Mode selection by strap and by software
	input  wire logic [1:0]             strap_mode,
	input  wire logic [1:0]             sw_mode,
	input  wire logic                   sw_mode_write,
	// Divider and multiplier factors
	input  wire logic [P_W-1:0]         p_div,
	input  wire logic [N_W-1:0]         n_mult,
	input  wire logic [K_W-1:0]         k_div,
	// Module clock requests
	input  wire logic [NUM_MODULES-1:0] module_enable,
	// Generated clocks
	output logic                        cpu_clock,
	output logic                        system_clock,
	output logic [NUM_MODULES-1:0]      module_clock,
	// Status
	output logic [1:0]                  active_mode,
	output logic                        clock_valid,
	output logic                        pll_locked,
	output logic                        switch_busy
);

	localparam int unsigned LIM_W = P_W + cgms_pkg::PERIOD_W;
	localparam int unsigned ACC_W = LIM_W + 1;

	cgms_pkg::cgms_state_t        state_reg, state_next;
	cgms_pkg::cgms_mode_t         cur_mode_reg, cur_mode_next;
	cgms_pkg::cgms_mode_t         req_mode_reg, req_mode_next;
	logic [cgms_pkg::TIMER_W-1:0] timer_reg, timer_next;
	logic                         osc_q_reg;
	logic                         osc_rise;
	logic [cgms_pkg::PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
	logic [cgms_pkg::PERIOD_W-1:0] period_reg, period_next;
	logic [ACC_W-1:0]             acc_reg, acc_next;
	logic                         vco_reg, vco_next;
	logic                         vco_rise_reg, vco_rise_next;
	logic [ACC_W-1:0]             acc_sum;
	logic [ACC_W-1:0]             lim;
	logic [ACC_W-1:0]             step;
	logic                         gate_reg, gate_next;
	logic                         sys_reg, sys_next;
	logic                         cpu_reg;
	logic [NUM_MODULES-1:0]       mod_gate_reg, mod_gate_next;
	logic [NUM_MODULES-1:0]       mod_clk_reg, mod_clk_next;
	logic                         locked_reg, locked_next;
	logic                         busy_reg, busy_next;
	logic                         p_out, p_rise;
	logic                         k_src, k_src_rise;
	logic                         k_out;
	logic                         src_sel;
	logic                         pll_mode;

	// Oscillator edge detection and period measurement for the VCO model.
	always_comb
	begin
		osc_rise     = oscillator_clock & ~osc_q_reg;
		per_cnt_next = osc_rise ? cgms_pkg::PERIOD_W'(1) : per_cnt_reg + cgms_pkg::PERIOD_W'(1);
		period_next  = osc_rise ? per_cnt_reg : period_reg;
	end

	cgms_divider #(.DIV_W(P_W)) u_pdiv (
		.clock    (clock),
		.rst      (rst),
		.src      (osc_q_reg),
		.src_rise (osc_rise),
		.divisor  (p_div),
		.out      (p_out),
		.out_rise (p_rise)
	);

	// VCO: toggles at twice osc*N/P in PLL mode, free-runs at base rate in base mode.
	always_comb
	begin
		pll_mode = (cur_mode_reg == cgms_pkg::CGMS_PLL) || (cur_mode_reg == cgms_pkg::CGMS_PLL_BASE);
		if (cur_mode_reg == cgms_pkg::CGMS_PLL_BASE)
		begin
			step = ACC_W'(cgms_pkg::VCO_BASE_STEP);
			lim  = ACC_W'(cgms_pkg::VCO_BASE_LIMIT);
		end
		else
		begin
			step = ACC_W'({n_mult, 1'b0});
			lim  = ACC_W'(LIM_W'(p_div) * LIM_W'(period_reg));
		end
		acc_sum       = acc_reg + step;
		acc_next      = acc_sum;
		vco_next      = vco_reg;
		if (!pll_mode || lim == '0)
		begin
			acc_next = '0;
			vco_next = 1'b0;
		end
		else if (acc_sum >= lim)
		begin
			acc_next = acc_sum - lim;
			vco_next = ~vco_reg;
		end
		vco_rise_next = vco_next & ~vco_reg;
	end

	// Output divider takes the VCO in both PLL modes and the input divider otherwise.
	// Direct mode bypasses both dividers.
	always_comb
	begin
		k_src      = pll_mode ? vco_reg : p_out;
		k_src_rise = pll_mode ? vco_rise_reg : p_rise;
		src_sel    = (cur_mode_reg == cgms_pkg::CGMS_DIRECT) ? osc_q_reg : k_out;
	end

	cgms_divider #(.DIV_W(K_W)) u_kdiv (
		.clock    (clock),
		.rst      (rst),
		.src      (k_src),
		.src_rise (k_src_rise),
		.divisor  (k_div),
		.out      (k_out),
		.out_rise ()
	);

	// Mode switch sequencer: stop on a low phase, settle, restart on a low phase.
	always_comb
	begin
		state_next    = state_reg;
		cur_mode_next = cur_mode_reg;
		req_mode_next = req_mode_reg;
		timer_next    = timer_reg;
		gate_next     = gate_reg;
		locked_next   = locked_reg;
		if (sw_mode_write && state_reg != cgms_pkg::ST_INIT)
			req_mode_next = cgms_pkg::cgms_mode_t'(sw_mode);
		unique case (state_reg)
			cgms_pkg::ST_INIT:
			begin
				gate_next  = 1'b0;
				timer_next = timer_reg + cgms_pkg::TIMER_W'(1);
				if (timer_reg >= cgms_pkg::TIMER_W'(cgms_pkg::INIT_CYCLES - 1))
				begin
					req_mode_next = cgms_pkg::cgms_mode_t'(strap_mode);
					cur_mode_next = cgms_pkg::cgms_mode_t'(strap_mode);
					timer_next    = '0;
					state_next    = cgms_pkg::ST_LOCK;
				end
			end
			cgms_pkg::ST_RUN:
			begin
				gate_next = 1'b1;
				if (req_mode_reg != cur_mode_reg)
					state_next = cgms_pkg::ST_DRAIN;
			end
			cgms_pkg::ST_DRAIN:
			begin
				if (!src_sel)
				begin
					gate_next     = 1'b0;
					cur_mode_next = req_mode_reg;
					locked_next   = 1'b0;
					timer_next    = '0;
					state_next    = cgms_pkg::ST_LOCK;
				end
			end
			cgms_pkg::ST_LOCK:
			begin
				timer_next = timer_reg + cgms_pkg::TIMER_W'(1);
				if (!pll_mode || timer_reg >= cgms_pkg::TIMER_W'(cgms_pkg::LOCK_CYCLES - 1))
				begin
					locked_next = pll_mode;
					timer_next  = '0;
					state_next  = cgms_pkg::ST_ARM;
				end
			end
			cgms_pkg::ST_ARM:
			begin
				if (!src_sel)
				begin
					gate_next  = 1'b1;
					state_next = cgms_pkg::ST_RUN;
				end
			end
			default:
			begin
				gate_next  = 1'b0;
				state_next = cgms_pkg::ST_INIT;
			end
		endcase
		sys_next = gate_next & src_sel;
		busy_next = (state_next != cgms_pkg::ST_RUN);
	end

	// Module gates change only while the system clock is low.
	always_comb
	begin
		mod_gate_next = sys_reg ? mod_gate_reg : module_enable;
		mod_clk_next  = {NUM_MODULES{sys_next}} & mod_gate_next;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg    <= cgms_pkg::ST_INIT;
			cur_mode_reg <= cgms_pkg::RESET_MODE;
			req_mode_reg <= cgms_pkg::RESET_MODE;
			timer_reg    <= '0;
			osc_q_reg    <= 1'b0;
			per_cnt_reg  <= '0;
			period_reg   <= '0;
			acc_reg      <= '0;
			vco_reg      <= 1'b0;
			vco_rise_reg <= 1'b0;
			gate_reg     <= 1'b0;
			sys_reg      <= 1'b0;
			cpu_reg      <= 1'b0;
			mod_gate_reg <= '0;
			mod_clk_reg  <= '0;
			locked_reg   <= 1'b0;
			busy_reg     <= 1'b1;
		end
		else
		begin
			state_reg    <= state_next;
			cur_mode_reg <= cur_mode_next;
			req_mode_reg <= req_mode_next;
			timer_reg    <= timer_next;
			osc_q_reg    <= oscillator_clock;
			per_cnt_reg  <= per_cnt_next;
			period_reg   <= period_next;
			acc_reg      <= acc_next;
			vco_reg      <= vco_next;
			vco_rise_reg <= vco_rise_next;
			gate_reg     <= gate_next;
			sys_reg      <= sys_next;
			cpu_reg      <= sys_next;
			mod_gate_reg <= mod_gate_next;
			mod_clk_reg  <= mod_clk_next;
			locked_reg   <= locked_next;
			busy_reg     <= busy_next;
		end
	end

	assign cpu_clock    = cpu_reg;
	assign system_clock = sys_reg;
	assign module_clock = mod_clk_reg;
	assign active_mode  = cur_mode_reg;
	assign clock_valid  = gate_reg;
	assign pll_locked   = locked_reg;
	assign switch_busy  = busy_reg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_running_in(cgms_pkg::cgms_mode_t m);
		state_reg == cgms_pkg::ST_RUN && cur_mode_reg == m && gate_reg;
	endsequence
	// The first edge after reset is released; rst is already low there.
	sequence s_reset_release;
		$fell(rst);
	endsequence

	AST_DIRECT_PASS: assert property (
		s_running_in(cgms_pkg::CGMS_DIRECT) |=> sys_reg == $past(osc_q_reg))
		else $error("Direct mode system clock differs from oscillator.");
	AST_PRESCALER_PATH: assert property (
		s_running_in(cgms_pkg::CGMS_PRESCALER) |=> sys_reg == $past(k_out) && vco_reg == 1'b0)
		else $error("Prescaler mode clock not from output divider or VCO active.");
	AST_CPU_EQ_SYS: assert property (
		cpu_reg == sys_reg)
		else $error("CPU clock differs from system clock.");
	AST_PLL_LOCK_WAIT: assert property (
		$rose(gate_reg) && $past(state_reg) == cgms_pkg::ST_ARM && pll_mode |-> locked_reg)
		else $error("Clock released from VCO before lock time elapsed.");
	AST_SW_SELECT: assert property (
		sw_mode_write && state_reg != cgms_pkg::ST_INIT |=> req_mode_reg == $past(sw_mode))
		else $error("Software mode request not taken.");
	AST_ARM_RELEASE: assert property (
		state_reg == cgms_pkg::ST_ARM && !src_sel |=> state_reg == cgms_pkg::ST_RUN && gate_reg)
		else $error("Switch did not complete on low source phase.");
	AST_MODULE_GATE: assert property (
		(mod_clk_reg & ~{NUM_MODULES{sys_reg}}) == '0)
		else $error("Module clock high while system clock low.");
	AST_INIT_HOLD: assert property (
		s_reset_release |-> (!gate_reg && !sys_reg)[*8])
		else $error("Clock released too early after reset.");
	AST_SAFE_EDGES: assert property (
		($fell(sys_reg) |-> !$past(src_sel)) and ($rose(sys_reg) |-> $past(src_sel)))
		else $error("System clock edge without matching source edge.");
endmodule
`default_nettype wire

/* File: testbench/cgms_osc_model.sv */
// Behavioural free-running oscillator seen through the sampling clock.
`timescale 1ns/1ps
`default_nettype none
module cgms_osc_model (
	// Sampling clock
	input  wire logic       clock,
	// Half period in sampling clocks, changeable for fast or slow sources
	input  wire logic [7:0] half_cycles,
	// Oscillator level
	output logic            osc_level
);
	logic [7:0] count_reg = 8'h00;
	logic       level_reg = 1'b0;

	always @(posedge clock)
	begin
		if (count_reg + 8'h01 >= half_cycles)
		begin
			count_reg <= 8'h00;
			level_reg <= ~level_reg;
		end
		else
			count_reg <= count_reg + 8'h01;
	end

	assign osc_level = level_reg;
endmodule
`default_nettype wire

/* File: testbench/clock_generation_mode_select_bench.sv */
// Self-checking bench for the clock generation mode select block.
`timescale 1ns/1ps
`default_nettype none
module clock_generation_mode_select_bench;
	logic        clock;
	logic        rst;
	logic        oscillator_clock;
	logic [7:0]  osc_half;
	logic [1:0]  strap_mode;
	logic [1:0]  sw_mode;
	logic        sw_mode_write;
	logic [3:0]  p_div;
	logic [5:0]  n_mult;
	logic [3:0]  k_div;
	logic [7:0]  module_enable;
	logic        cpu_clock;
	logic        system_clock;
	logic [7:0]  module_clock;
	logic [1:0]  active_mode;
	logic        clock_valid;
	logic        pll_locked;
	logic        switch_busy;
	logic [15:0] per;
	int          err_total;
	int          n_tests;

	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	cgms_osc_model u_osc (
		.clock      (clock),
		.half_cycles(osc_half),
		.osc_level  (oscillator_clock)
	);

	cgms_core u_dut (
		.clock           (clock),
		.rst             (rst),
		.oscillator_clock(oscillator_clock),
		.strap_mode      (strap_mode),
		.sw_mode         (sw_mode),
		.sw_mode_write   (sw_mode_write),
		.p_div           (p_div),
		.n_mult          (n_mult),
		.k_div           (k_div),
		.module_enable   (module_enable),
		.cpu_clock       (cpu_clock),
		.system_clock    (system_clock),
		.module_clock    (module_clock),
		.active_mode     (active_mode),
		.clock_valid     (clock_valid),
		.pll_locked      (pll_locked),
		.switch_busy     (switch_busy)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Counts sampling cycles until system_clock shows level v, bounded.
	task automatic wait_level(input logic v, inout logic [15:0] n);
		int k;
		k = 0;
		while (system_clock !== v && k < 2000)
		begin
			@(negedge clock);
			n = n + 16'h0001;
			k++;
		end
	endtask

	// Rise-to-rise period of system_clock, taken on the second full period.
	task automatic period(output logic [15:0] p);
		logic [15:0] d;
		d = 16'h0000;
		wait_level(1'b0, d);
		wait_level(1'b1, d);
		wait_level(1'b0, d);
		wait_level(1'b1, d);
		p = 16'h0000;
		wait_level(1'b0, p);
		wait_level(1'b1, p);
	endtask

	task automatic switch_to(input logic [1:0] m);
		int k;
		@(posedge clock);
		sw_mode <= m;
		sw_mode_write <= 1'b1;
		@(posedge clock);
		sw_mode_write <= 1'b0;
		repeat (3) @(negedge clock);
		check({15'h0000, switch_busy}, 16'h0001);
		k = 0;
		while ((switch_busy !== 1'b0 || clock_valid !== 1'b1) && k < 3000)
		begin
			@(negedge clock);
			k++;
		end
		check({14'h0000, active_mode}, {14'h0000, m});
	endtask

	task automatic t_reset();
		logic [15:0] n;
		repeat (19) @(posedge clock);
		@(negedge clock);
		check({12'h000, system_clock, clock_valid, switch_busy, pll_locked}, 16'h0002);
		check({14'h0000, active_mode}, 16'h0000);
		@(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		sw_mode_write <= 1'b1;
		@(posedge clock);
		sw_mode_write <= 1'b0;
		n = 16'h0003;
		while (clock_valid !== 1'b1 && n < 16'h0400)
		begin
			@(negedge clock);
			n = n + 16'h0001;
		end
		check({15'h0000, n >= 16'(cgms_pkg::INIT_CYCLES + 2)}, 16'h0001);
		check({15'h0000, clock_valid}, 16'h0001);
		check({14'h0000, active_mode}, 16'h0001);
		$display("test reset and strap done");
	endtask

	task automatic t_prescaler();
		period(per);
		check(per, 16'h0018);
		$display("test prescaler done");
	endtask

	task automatic t_direct();
		osc_half <= 8'h03;
		switch_to(2'h0);
		period(per);
		check(per, 16'h0006);
		wait_level(1'b0, per);
		@(posedge clock);
		module_enable <= 8'hC3;
		wait_level(1'b1, per);
		check({8'h00, module_clock}, 16'h00C3);
		$display("test direct done");
	endtask

	task automatic t_pll(input logic [1:0] m, input logic [15:0] exp_per);
		switch_to(m);
		check({15'h0000, pll_locked}, 16'h0001);
		period(per);
		check(per, exp_per);
		$display("test pll mode %0d done", m);
	endtask

	task automatic t_back_to_back();
		@(posedge clock);
		sw_mode <= 2'h3;
		sw_mode_write <= 1'b1;
		@(posedge clock);
		sw_mode <= 2'h0;
		switch_to(2'h0);
		check({15'h0000, pll_locked}, 16'h0000);
		period(per);
		check(per, 16'h0006);
		$display("test back to back done");
	endtask

	// Released clocks must pair up, and gated modules must see no edges.
	always @(negedge clock)
	begin
		if (rst === 1'b0 && clock_valid === 1'b1)
		begin
			check({15'h0000, cpu_clock}, {15'h0000, system_clock});
			check({8'h00, module_clock}, {8'h00, system_clock ? module_enable : 8'h00});
		end
	end

	initial
	begin
		repeat (60000) @(posedge clock);
		$display("watchdog expired");
		err_total++;
		complete_run();
	end

	initial
	begin
		rst = 1'b1;
		osc_half = 8'h02;
		strap_mode = 2'h1;
		sw_mode = 2'h0;
		sw_mode_write = 1'b0;
		p_div = 4'h2;
		n_mult = 6'h04;
		k_div = 4'h3;
		module_enable = 8'h5A;
		err_total = 0;
		n_tests = 0;
		t_reset();
		t_prescaler();
		t_direct();
		t_pll(2'h2, 16'(2 * osc_half * p_div * k_div / n_mult));
		t_pll(2'h3, 16'(2 * cgms_pkg::VCO_BASE_LIMIT * k_div / cgms_pkg::VCO_BASE_STEP));
		t_back_to_back();
		complete_run();
	end
endmodule
`default_nettype wire
